//--- src/cdc_pkg.sv
// Shared constants for the crypto descriptor channel engine
package cdc_pkg;
   localparam int          NCH          = 9;
   localparam int          NEU          = 4;
   localparam int          CH_BUF_BYTES = 2048;
   localparam int          CH_BUF_WORDS = CH_BUF_BYTES / 4;
   localparam int          BUF_AW       = 13;
   localparam logic [3:0]  NXT_PTR_IDX  = 4'he;
   localparam logic [31:0] MAX_LEN      = 32'h800;
   localparam logic [2:0]  PAIR_FIRST   = 3'h1;
   localparam logic [2:0]  PAIR_DOUT    = 3'h4;
   localparam logic [2:0]  PAIR_LAST    = 3'h5;
   // Register map, region codes in address bits 9:8 and register indices in bits 3:2
   localparam logic [1:0]  RGN_CH       = 2'h0;
   localparam logic [1:0]  RGN_EUCFG    = 2'h1;
   localparam logic [1:0]  RGN_EUWIN    = 2'h2;
   localparam logic [1:0]  CH_NEXT      = 2'h0;
   localparam logic [1:0]  CH_CFG       = 2'h1;
   localparam logic [1:0]  CH_STAT      = 2'h2;
   localparam int          CFG_CHAIN    = 0;
   localparam int          ST_BUSY      = 0;
   localparam int          ST_DONE      = 1;
   localparam int          ST_LEN       = 2;
   localparam int          ST_ILL       = 3;
   // Execution unit assignment modes, owner in bits 7:4
   localparam logic [1:0]  EU_HOST      = 2'h0;
   localparam logic [1:0]  EU_STATIC    = 2'h1;
   localparam logic [1:0]  EU_DYN       = 2'h2;
   // Unit types: units 0 and 1 cipher, 2 hash, 3 public key
   localparam logic [7:0]  EU_TYPES     = 8'h90;
   // Header fields
   localparam int          HDR_TYPE     = 28;
   localparam int          HDR_MODE     = 20;
   localparam int          HDR_DONE     = 16;
endpackage : cdc_pkg

//--- src/cdc_buf_if.sv
// Descriptor buffer port between engine and buffer memory
`timescale 1ns/1ps
interface cdc_buf_if;
   import cdc_pkg::*;
   logic              we;
   logic [BUF_AW-1:0] waddr;
   logic [BUF_AW-1:0] raddr;
   logic [31:0]       wdata;
   logic [31:0]       rdata;
   modport ctl (output we, waddr, raddr, wdata, input rdata);
   modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface : cdc_buf_if

//--- src/cdc_desc_ram.sv
// Descriptor buffer memory, one 2 KByte slot per channel
`timescale 1ns/1ps
module cdc_desc_ram
   import cdc_pkg::*;
(
   input wire logic mclk,
   cdc_buf_if.mem   bus
);
   logic [31:0] ram [NCH*CH_BUF_WORDS];
   logic [31:0] rdata_reg;

   always_ff @(posedge mclk)
   begin
      if (bus.we)
         ram[bus.waddr] <= bus.wdata;
      rdata_reg <= ram[bus.raddr];
   end

   assign bus.rdata = rdata_reg;
endmodule : cdc_desc_ram

//--- src/cdc_channels.sv
// Crypto descriptor channel engine with register slave
`timescale 1ns/1ps
module cdc_channels
   import cdc_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire logic [9:0]     avs_address,
   input  wire logic           avs_read,
   input  wire logic           avs_write,
   input  wire logic [31:0]    avs_writedata,
   input  wire logic [3:0]     avs_byteenable,
   output logic      [31:0]    avs_readdata,
   output logic                avs_waitrequest,
   output logic      [31:0]    m_address,
   output logic                m_read,
   output logic                m_write,
   output logic      [31:0]    m_writedata,
   input  wire logic [31:0]    m_readdata,
   input  wire logic           m_waitrequest,
   output logic      [1:0]     eu_sel,
   output logic      [7:0]     eu_mode,
   output logic                eu_load,
   output logic      [31:0]    eu_din,
   output logic                eu_start,
   output logic                eu_unload,
   output logic                eu_reset,
   input  wire logic [31:0]    eu_dout,
   input  wire logic [NEU-1:0] eu_done,
   input  wire logic [NEU-1:0] eu_idle,
   output logic                eu_reg_wr,
   output logic      [5:0]     eu_reg_addr,
   output logic      [31:0]    eu_reg_wdata,
   input  wire logic [31:0]    eu_reg_rdata,
   output logic                irq
);
   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_ALLOC, S_PA, S_PB, S_PC, S_PD,
      S_RD, S_RUN, S_WL, S_WR, S_WG, S_WB, S_END
   } cdc_state_t;

   typedef struct packed {
      cdc_state_t              st;
      logic [3:0]              ch;
      logic [3:0]              rr;
      logic [3:0]              idx;
      logic [2:0]              pair;
      logic [11:0]             len;
      logic [31:0]             base;
      logic [31:0]             ptr;
      logic [31:0]             hdr;
      logic [31:0]             nxt;
      logic [31:0]             prev;
      logic [9:0]              cnt;
      logic [9:0]              emit;
      logic                    prim;
      logic                    ran;
      logic                    lerr;
      logic                    ill;
      logic [1:0]              eu;
      logic [NCH-1:0][31:0]    nda;
      logic [NCH-1:0]          pend;
      logic [NCH-1:0]          chain;
      logic [NCH-1:0]          done;
      logic [NCH-1:0]          elen;
      logic [NCH-1:0]          eill;
      logic [NEU-1:0][7:0]     eucfg;
      logic [1:0]              aph;
      logic                    awr;
      logic [31:0]             ard;
      logic                    mrd;
      logic                    mwr;
      logic [31:0]             maddr;
      logic [31:0]             mwd;
      logic [7:0]              emode;
      logic                    eload;
      logic [31:0]             edin;
      logic                    estart;
      logic                    eunl;
      logic                    erst;
      logic                    ewr;
      logic [5:0]              eaddr;
      logic [31:0]             ewd;
      logic                    irq;
      logic                    bwe;
      logic [BUF_AW-1:0]       bwa;
      logic [BUF_AW-1:0]       bra;
      logic [31:0]             bwd;
   } cdc_regs_t;

   cdc_regs_t s_reg;
   cdc_regs_t s_next;
   cdc_buf_if buf_if ();

   cdc_desc_ram u_ram (
      .mclk (mclk),
      .bus  (buf_if.mem)
   );

   function automatic logic [9:0] nwords(input logic [11:0] l);
      return 10'((13'(l) + 13'h3) >> 2);
   endfunction : nwords

   function automatic logic chan_busy(input logic [3:0] c);
      return s_reg.pend[c] | (s_reg.st != S_IDLE && s_reg.ch == c);
   endfunction : chan_busy

   function automatic logic [31:0] rd_mux(input logic [9:0] a);
      logic [3:0]  c;
      logic [31:0] r;
      c = a[7:4];
      r = 32'h0;
      if (a[9:8] == RGN_CH && c < 4'(NCH))
      begin
         if (a[3:2] == CH_NEXT)
            r = s_reg.nda[c];
         else if (a[3:2] == CH_CFG)
            r[CFG_CHAIN] = s_reg.chain[c];
         else if (a[3:2] == CH_STAT)
         begin
            r[ST_BUSY] = chan_busy(c);
            r[ST_DONE] = s_reg.done[c];
            r[ST_LEN]  = s_reg.elen[c];
            r[ST_ILL]  = s_reg.eill[c];
         end
      end
      else if (a[9:8] == RGN_EUCFG)
         r = {24'h0, s_reg.eucfg[a[3:2]]};
      else if (a[9:8] == RGN_EUWIN)
         r = eu_reg_rdata;
      return r;
   endfunction : rd_mux

   // Result: {found, illegal, unit}
   function automatic logic [3:0] pick_eu(input logic [1:0] ty,
                                          input logic [3:0] c);
      logic       fnd;
      logic       any;
      logic       ok;
      logic [1:0] u;
      fnd = 1'b0;
      any = 1'b0;
      u   = 2'h0;
      for (int i = NEU - 1; i >= 0; i--)
      begin
         ok = (s_reg.eucfg[i][1:0] == EU_DYN) ||
              (s_reg.eucfg[i][1:0] == EU_STATIC &&
               s_reg.eucfg[i][7:4] == c);
         if (EU_TYPES[2*i +: 2] == ty && ok)
         begin
            any = 1'b1;
            if (eu_idle[i])
            begin
               fnd = 1'b1;
               u   = 2'(i);
            end
         end
      end
      return {fnd, ~any, u};
   endfunction : pick_eu

   always_comb
   begin
      cdc_regs_t   n;
      logic [3:0]  c;
      logic [3:0]  pk;
      logic        fnd;
      logic [3:0]  sel;
      logic [63:0] sh;
      logic [NCH-1:0] wset;
      n   = s_reg;
      c   = avs_address[7:4];
      pk  = 4'h0;
      fnd = 1'b0;
      sel = 4'h0;
      wset = '0;
      sh  = {m_readdata, s_reg.prev} >> {s_reg.ptr[1:0], 3'b000};
      n.eload  = 1'b0;
      n.estart = 1'b0;
      n.eunl   = 1'b0;
      n.erst   = 1'b0;
      n.ewr    = 1'b0;
      n.bwe    = 1'b0;

      // Three-cycle slave so the unit window read data settles
      unique case (s_reg.aph)
         2'h0:
         begin
            if (avs_read | avs_write)
            begin
               n.aph   = 2'h1;
               n.eaddr = avs_address[7:2];
            end
         end
         2'h1:
         begin
            n.ard = rd_mux(avs_address);
            n.awr = 1'b0;
            n.aph = 2'h2;
         end
         2'h2:
         begin
            n.awr = 1'b1;
            n.aph = 2'h0;
            if (avs_write && avs_byteenable == 4'hf)
            begin
               if (avs_address[9:8] == RGN_CH && c < 4'(NCH))
               begin
                  if (avs_address[3:2] == CH_NEXT)
                  begin
                     n.nda[c]  = avs_writedata;
                     n.pend[c] = 1'b1;
                     wset[c]   = 1'b1;
                  end
                  else if (avs_address[3:2] == CH_CFG)
                     n.chain[c] = avs_writedata[CFG_CHAIN];
                  else if (avs_address[3:2] == CH_STAT)
                  begin
                     n.done[c] = s_reg.done[c] & ~avs_writedata[ST_DONE];
                     n.elen[c] = s_reg.elen[c] & ~avs_writedata[ST_LEN];
                     n.eill[c] = s_reg.eill[c] & ~avs_writedata[ST_ILL];
                  end
               end
               else if (avs_address[9:8] == RGN_EUCFG)
                  n.eucfg[avs_address[3:2]] = avs_writedata[7:0];
               else if (avs_address[9:8] == RGN_EUWIN)
               begin
                  n.ewr = 1'b1;
                  n.ewd = avs_writedata;
               end
            end
         end
         default: n.aph = 2'h0;
      endcase

      unique case (s_reg.st)
         S_IDLE:
         begin
            // Search downward so the nearest channel after rr wins
            for (int i = NCH; i >= 1; i--)
            begin
               pk = 4'((int'(s_reg.rr) + i) % NCH);
               if (s_reg.pend[pk])
               begin
                  fnd = 1'b1;
                  sel = pk;
               end
            end
            if (fnd)
            begin
               n.ch        = sel;
               n.rr        = sel;
               // A host start in this same cycle must not be lost
               n.pend[sel] = wset[sel];
               n.base      = s_reg.nda[sel];
               n.idx       = 4'h0;
               n.lerr      = 1'b0;
               n.ill       = 1'b0;
               n.ran       = 1'b0;
               n.st        = S_FETCH;
            end
         end
         S_FETCH:
         begin
            if (!m_waitrequest)
            begin
               n.bwe = 1'b1;
               n.bwa = {s_reg.ch, 5'h0, s_reg.idx};
               n.bwd = m_readdata;
               n.idx = s_reg.idx + 4'h1;
               if (s_reg.idx == 4'h0)
                  n.hdr = m_readdata;
               if (s_reg.idx[0] && m_readdata > MAX_LEN)
                  n.lerr = 1'b1;
               if (s_reg.idx == NXT_PTR_IDX)
               begin
                  n.nxt = m_readdata;
                  n.st  = n.lerr ? S_END : S_ALLOC;
               end
            end
         end
         S_ALLOC:
         begin
            pk = pick_eu(s_reg.hdr[HDR_TYPE +: 2], s_reg.ch);
            if (pk[3])
            begin
               n.eu    = pk[1:0];
               n.emode = s_reg.hdr[HDR_MODE +: 8];
               n.pair  = PAIR_FIRST;
               n.st    = S_PA;
            end
            else if (pk[2])
            begin
               n.ill = 1'b1;
               n.st  = S_END;
            end
            // Otherwise wait here for a unit to go idle
         end
         S_PA:
         begin
            n.bra = {s_reg.ch, 5'h0, 4'({s_reg.pair, 1'b0}) - 4'h1};
            n.st  = S_PB;
         end
         S_PB:
         begin
            n.bra = {s_reg.ch, 5'h0, 4'({s_reg.pair, 1'b0})};
            n.st  = S_PC;
         end
         S_PC:
         begin
            n.len = buf_if.rdata[11:0];
            n.st  = S_PD;
         end
         S_PD:
         begin
            n.ptr  = buf_if.rdata;
            n.cnt  = 10'h0;
            n.emit = 10'h0;
            n.prim = 1'b0;
            if (s_reg.pair >= PAIR_DOUT && !s_reg.ran)
            begin
               n.estart = 1'b1;
               n.st     = S_RUN;
            end
            else if (s_reg.len == 12'h0)
            begin
               n.pair = s_reg.pair + 3'h1;
               n.st   = (s_reg.pair == PAIR_LAST) ? S_WB : S_PA;
            end
            else
               n.st = (s_reg.pair < PAIR_DOUT) ? S_RD : S_WL;
         end
         S_RD:
         begin
            if (!m_waitrequest)
            begin
               n.cnt  = s_reg.cnt + 10'h1;
               n.prev = m_readdata;
               if (s_reg.ptr[1:0] == 2'h0 || s_reg.prim)
               begin
                  n.eload = 1'b1;
                  n.edin  = (s_reg.ptr[1:0] == 2'h0) ? m_readdata
                                                    : sh[31:0];
                  n.emit  = s_reg.emit + 10'h1;
                  if (n.emit == nwords(s_reg.len))
                  begin
                     n.pair = s_reg.pair + 3'h1;
                     n.st   = S_PA;
                  end
               end
               else
                  n.prim = 1'b1;
            end
         end
         S_RUN:
         begin
            if (eu_done[s_reg.eu])
            begin
               n.ran = 1'b1;
               n.st  = S_PD;
            end
         end
         S_WL:
         begin
            n.mwd = eu_dout;
            n.st  = S_WR;
         end
         S_WR:
         begin
            if (!m_waitrequest)
            begin
               n.eunl = 1'b1;
               n.cnt  = s_reg.cnt + 10'h1;
               n.st   = S_WG;
               if (n.cnt == nwords(s_reg.len))
               begin
                  n.pair = s_reg.pair + 3'h1;
                  n.st   = (s_reg.pair == PAIR_LAST) ? S_WB : S_PA;
               end
            end
         end
         S_WG: n.st = S_WL;
         S_WB:
         begin
            if (!m_waitrequest)
            begin
               n.erst = (s_reg.eucfg[s_reg.eu][1:0] == EU_DYN);
               n.st   = S_END;
            end
         end
         S_END:
         begin
            n.st = S_IDLE;
            if (s_reg.lerr)
               n.elen[s_reg.ch] = 1'b1;
            else if (s_reg.ill)
               n.eill[s_reg.ch] = 1'b1;
            else
            begin
               if (!s_reg.chain[s_reg.ch] || s_reg.nxt == 32'h0)
                  n.done[s_reg.ch] = 1'b1;
               if (s_reg.nxt != 32'h0)
               begin
                  n.nda[s_reg.ch]  = s_reg.nxt;
                  n.pend[s_reg.ch] = 1'b1;
               end
            end
         end
      endcase

      // Master path is 32 bits wide; wider beats belong to the bus core
      n.mrd = (n.st == S_FETCH) || (n.st == S_RD);
      n.mwr = (n.st == S_WR) || (n.st == S_WB);
      if (n.st == S_FETCH)
         n.maddr = n.base + {26'h0, n.idx, 2'b00};
      else if (n.st == S_WB)
         n.maddr = {n.base[31:2], 2'b00};
      else
         n.maddr = {n.ptr[31:2] + 30'(n.cnt), 2'b00};
      if (n.st == S_WB)
         n.mwd = n.hdr | (32'h1 << HDR_DONE);
      n.irq = |(n.done | n.elen | n.eill);
      s_next = n;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg     <= '0;
         s_reg.awr <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   assign buf_if.we       = s_reg.bwe;
   assign buf_if.waddr    = s_reg.bwa;
   assign buf_if.wdata    = s_reg.bwd;
   assign buf_if.raddr    = s_reg.bra;
   assign avs_readdata    = s_reg.ard;
   assign avs_waitrequest = s_reg.awr;
   assign m_address       = s_reg.maddr;
   assign m_read          = s_reg.mrd;
   assign m_write         = s_reg.mwr;
   assign m_writedata     = s_reg.mwd;
   assign eu_sel          = s_reg.eu;
   assign eu_mode         = s_reg.emode;
   assign eu_load         = s_reg.eload;
   assign eu_din          = s_reg.edin;
   assign eu_start        = s_reg.estart;
   assign eu_unload       = s_reg.eunl;
   assign eu_reset        = s_reg.erst;
   assign eu_reg_wr       = s_reg.ewr;
   assign eu_reg_addr     = s_reg.eaddr;
   assign eu_reg_wdata    = s_reg.ewd;
   assign irq             = s_reg.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_fetch_last;
      s_reg.st == S_FETCH && s_reg.idx == NXT_PTR_IDX && !m_waitrequest;
   endsequence
   sequence s_grant;
      s_reg.st == S_ALLOC ##1 s_reg.st == S_PA;
   endsequence
   sequence s_ok_end;
      s_reg.st == S_END && !s_reg.lerr && !s_reg.ill;
   endsequence

   property p_wr_aligned;
      m_write |-> m_address[1:0] == 2'b00;
   endproperty
   a_wr_aligned: assert property (p_wr_aligned)
      else $error("initiator write not word aligned");

   property p_fixed_fetch;
      s_fetch_last |=> !m_read ##0 (s_reg.st inside {S_ALLOC, S_END});
   endproperty
   a_fixed_fetch: assert property (p_fixed_fetch)
      else $error("descriptor fetch did not stop after last word");

   property p_skip_zero;
      s_reg.st == S_PD && s_reg.len == 12'h0 && s_reg.pair < PAIR_DOUT
         |=> s_reg.st == S_PA && !m_read && !m_write;
   endproperty
   a_skip_zero: assert property (p_skip_zero)
      else $error("zero length pair caused a transfer");

   property p_writeback;
      s_reg.st == S_WB |-> m_write &&
         m_writedata == (s_reg.hdr | (32'h1 << HDR_DONE));
   endproperty
   a_writeback: assert property (p_writeback)
      else $error("header write-back value wrong");

   property p_chain_next;
      s_ok_end ##0 s_reg.nxt != 32'h0 |=>
         s_reg.pend[$past(s_reg.ch)] ##0 s_reg.nda[$past(s_reg.ch)] ==
         $past(s_reg.nxt);
   endproperty
   a_chain_next: assert property (p_chain_next)
      else $error("non-zero next address not queued");

   property p_done_each;
      s_ok_end ##0 !s_reg.chain[s_reg.ch] |=>
         s_reg.done[$past(s_reg.ch)] && irq;
   endproperty
   a_done_each: assert property (p_done_each)
      else $error("per-descriptor completion not flagged");

   property p_len_error;
      s_reg.st == S_END && s_reg.lerr |=>
         s_reg.elen[$past(s_reg.ch)] && irq && s_reg.st == S_IDLE;
   endproperty
   a_len_error: assert property (p_len_error)
      else $error("length error not reported");

   property p_grant_owner;
      s_grant |-> s_reg.eucfg[s_reg.eu][1:0] == EU_DYN ||
         (s_reg.eucfg[s_reg.eu][1:0] == EU_STATIC &&
          s_reg.eucfg[s_reg.eu][7:4] == s_reg.ch);
   endproperty
   a_grant_owner: assert property (p_grant_owner)
      else $error("unit granted to a channel that may not use it");
endmodule : cdc_channels

//--- verification/cdc_far_model.sv
// Host memory and execution unit stand-in behind the engine
`timescale 1ns/1ps
module cdc_far_model
   import cdc_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire logic [31:0]    m_address,
   input  wire logic           m_read,
   input  wire logic           m_write,
   input  wire logic [31:0]    m_writedata,
   output logic      [31:0]    m_readdata,
   output logic                m_waitrequest,
   input  wire logic           eu_start,
   output logic      [NEU-1:0] eu_done,
   output logic      [NEU-1:0] eu_idle,
   output logic      [31:0]    eu_dout
);
   logic [31:0] mem [0:255];
   logic [1:0]  stall_reg;
   logic [2:0]  run_reg;
   logic        done_reg;
   logic [31:0] last_reg;
   // Every fourth cycle stalls, so bursts meet slow answers too
   assign m_waitrequest = (stall_reg == 2'h3);
   // Idle data bus flips each cycle instead of holding the last word
   assign m_readdata = (m_read && !m_waitrequest) ?
                       mem[m_address[9:2]] : ~last_reg;
   assign eu_idle = 4'hf;
   // Stale done from the last run drops as soon as a new run starts
   assign eu_done = {NEU{done_reg && !eu_start}};
   assign eu_dout = 32'ha5a5_0001;
   always @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
         stall_reg <= 2'h0;
         run_reg <= 3'h0;
         done_reg <= 1'b0;
         last_reg <= 32'h0;
      end
      else
      begin
         stall_reg <= stall_reg + 2'h1;
         last_reg <= m_readdata;
         if (m_write && !m_waitrequest)
            mem[m_address[9:2]] <= m_writedata;
         if (eu_start)
         begin
            done_reg <= 1'b0;
            run_reg <= 3'h4;
         end
         else if (run_reg != 3'h0)
            run_reg <= run_reg - 3'h1;
         if (run_reg == 3'h1)
            done_reg <= 1'b1;
      end
endmodule : cdc_far_model

//--- verification/crypto_descriptor_channels_bench.sv
// Self-checking bench for the descriptor channel engine
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module crypto_descriptor_channels_bench
   import cdc_pkg::*;
;
   logic mclk = 0, rst_n = 0, rd = 0, wr = 0, wt, irq, mr, mw, mwt, st;
   logic eld, eul, ers, ewr;
   logic [7:0] emd;
   logic [1:0] esl;
   logic [9:0] a = 0;
   logic [31:0] wd = 0, rdat, ma, mwd, mrd, dout, ereg, q, din, ewd;
   logic [5:0] era;
   logic [NEU-1:0] dn, idl;
   int n_errors = 0, checked = 0, cyc = 0;
   int nld = 0, nul = 0, nrs = 0, nrw = 0;
   assign ereg = {26'h0, era} ^ 32'h5a00_0000;
   always #5 mclk = ~mclk;
   cdc_channels u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(a),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
      .m_address(ma), .m_read(mr), .m_write(mw), .m_writedata(mwd),
      .m_readdata(mrd), .m_waitrequest(mwt), .eu_sel(esl), .eu_mode(emd),
      .eu_load(eld), .eu_din(din), .eu_start(st), .eu_unload(eul),
      .eu_reset(ers), .eu_dout(dout), .eu_done(dn), .eu_idle(idl),
      .eu_reg_wr(ewr), .eu_reg_addr(era), .eu_reg_wdata(ewd),
      .eu_reg_rdata(ereg), .irq(irq));
   cdc_far_model u_far (.mclk(mclk), .rst_n(rst_n), .m_address(ma),
      .m_read(mr), .m_write(mw), .m_writedata(mwd), .m_readdata(mrd),
      .m_waitrequest(mwt), .eu_start(st), .eu_done(dn), .eu_idle(idl),
      .eu_dout(dout));
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [9:0] ad,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      a <= ad;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge mclk); while (wt !== 1'b0);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wait_st(input logic [9:0] ad);
      q = 0;
      for (int i = 0; i < 300 && q[3:1] == 3'h0; i++)
         bus(0, ad, 0, q);
   endtask : wait_st
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic t_desc;
      bus(1, 10'h100, 2, q);
      bus(1, 10'h004, 1, q);
      bus(1, 10'h000, 32'h40, q);
      wait_st(10'h008);
      `CHK("status", 2, q);
      `CHK("irq", 1, irq);
      `CHK("header", 32'h0121_0000, u_far.mem[16]);
      `CHK("next header", 32'h0121_0000, u_far.mem[224]);
      `CHK("result", 32'ha5a5_0001, u_far.mem[96]);
      `CHK("skipped", 0, u_far.mem[88]);
      `CHK("mode", 8'h12, emd);
      `CHK("unit", 0, esl);
      `CHK("realigned", 32'h9a12_3456, din);
      `CHK("loads", 3, nld);
      `CHK("unloads", 1, nul);
      `CHK("unit resets", 2, nrs);
      bus(1, 10'h008, 32'he, q);
      repeat (2) @(posedge mclk);
      `CHK("irq clear", 0, irq);
      $display("descriptor test done");
   endtask : t_desc
   task automatic t_len;
      bus(1, 10'h010, 32'h200, q);
      wait_st(10'h018);
      `CHK("len status", 4, q);
      `CHK("no writeback", 32'h0120_0000, u_far.mem[128]);
      bus(1, 10'h020, 32'h300, q);
      wait_st(10'h028);
      `CHK("illegal status", 8, q);
      `CHK("host unit", 32'h1000_0000, u_far.mem[192]);
      bus(1, 10'h208, 32'h77, q);
      bus(0, 10'h3f0, 0, q);
      `CHK("unmapped", 0, q);
      bus(0, 10'h204, 0, q);
      `CHK("unit window", 32'h5a00_0001, q);
      `CHK("unit writes", 1, nrw);
      `CHK("unit wdata", 32'h77, ewd);
      $display("length and map test done");
   endtask : t_len
   always @(posedge mclk)
   begin
      cyc++;
      nld += (eld === 1'b1);
      nul += (eul === 1'b1);
      nrs += (ers === 1'b1);
      nrw += (ewr === 1'b1);
      if (cyc == 20000)
      begin
         n_errors++;
         summarize();
      end
   end
   initial
   begin
      for (int i = 0; i < 256; i++)
         u_far.mem[i] = 32'h0;
      // Fixed size, unused pairs zero and next link to a second descriptor at 0x380
      u_far.mem[16] = 32'h0120_0000;
      u_far.mem[19] = 8;
      u_far.mem[20] = 32'h100;
      u_far.mem[21] = 4;
      u_far.mem[22] = 32'h111;
      u_far.mem[23] = 4;
      u_far.mem[24] = 32'h180;
      // Zero length with a live pointer must still be skipped
      u_far.mem[26] = 32'h160;
      u_far.mem[30] = 32'h380;
      u_far.mem[68] = 32'h1234_5678;
      u_far.mem[69] = 32'h9a;
      u_far.mem[192] = 32'h1000_0000;
      u_far.mem[224] = 32'h0120_0000;
      u_far.mem[128] = 32'h0120_0000;
      u_far.mem[133] = 32'h801;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_desc();
      t_len();
      summarize();
   end
endmodule : crypto_descriptor_channels_bench
